//--- design/fsk_regs.svh
// Register indices, field positions and reset values of the flash security block.
// Assumes a 32-bit Avalon-MM bus: byte address = 4 * register index.
`ifndef FSK_REGS_SVH
`define FSK_REGS_SVH

// ****************************************
// Register indices
// ****************************************
`define FSK_IDX_OPT 16'h1821
`define FSK_IDX_CFG 16'h1823
`define FSK_IDX_PROT 16'h1824
`define FSK_IDX_KSTAT 16'h1828
`define FSK_IDX_KEY_LO 16'hFFB0
`define FSK_IDX_KEY_HI 16'hFFB7
`define FSK_IDX_NV_PROTECT_BYTE 16'hFFBD
`define FSK_IDX_NV_OPTION_BYTE 16'hFFBF

// ****************************************
// Field positions and masks
// ****************************************
`define FSK_OPT_KEY_ENABLE_BIT 7
`define FSK_OPT_NORED 6
`define FSK_OPT_MASK 8'hC3
`define FSK_SEC_OPEN 2'h2
`define FSK_CFG_KEY_ACCESS_SELECT 5
`define FSK_CFG_MASK 8'h20
`define FSK_PROT_DIS 0
`define FSK_KST_OPEN 0
`define FSK_KST_REJ 1
`define FSK_KST_ERASED 2

// ****************************************
// Reset values
// ****************************************
`define FSK_RST_OPT 8'h00
`define FSK_RST_CFG 8'h00
`define FSK_RST_PROT 8'hFF

`endif

//--- design/fsk_pkg.sv
// Types shared by the flash security block.
// Assumes nothing of its surroundings.
package fsk_pkg;

   // Bus answer stages
   typedef enum logic {FSK_BUS_IDLE, FSK_BUS_ANSWER} fsk_bus_e;

   typedef logic [7:0] fsk_byte_t;

   // Byte of the key at position idx; position 0 is the most significant byte
   function automatic fsk_byte_t fsk_key_byte(input logic [63:0] key, input logic [2:0] idx);
      logic [2:0] pos;
      pos = 3'(3'h7 - idx);
      return key[{pos, 3'h0} +: 8];
   endfunction

endpackage

//--- design/fsk_key_cmp.sv
// Gathers the eight bytes of an entered key and compares them with the stored key.
// Assumes its caller only offers bytes that passed all access checks.
`timescale 1ns/1ps
`include "fsk_regs.svh"

module fsk_key_cmp import fsk_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Entered bytes
   input wire logic byte_vld,
   input wire logic [2:0] byte_idx,
   input wire logic [7:0] byte_data,
   input wire logic abort,
   // Stored key
   input wire logic [63:0] ref_key,
   // Result, one-cycle pulses
   output logic match_pulse,
   output logic miss_pulse
);

   logic [7:0] got_reg;
   logic [63:0] key_reg;
   logic [63:0] key_next;
   logic [7:0] got_next;
   logic [2:0] pos;

   // Merge the arriving byte so the last byte is compared in its own cycle
   always_comb begin
      pos = 3'(3'h7 - byte_idx);
      key_next = key_reg;
      key_next[{pos, 3'h0} +: 8] = byte_data;
      got_next = got_reg | (8'h01 << byte_idx);
   end

   // Collect bytes; a full set is consumed so a retry starts clean
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         got_reg <= 8'h00;
         key_reg <= 64'h0;
      end else if (abort) begin
         got_reg <= 8'h00;
      end else if (byte_vld) begin
         key_reg <= key_next;
         got_reg <= (got_next == 8'hFF) ? 8'h00 : got_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         match_pulse <= 1'b0;
         miss_pulse <= 1'b0;
      end else begin
         match_pulse <= !abort && byte_vld && got_next == 8'hFF && key_next == ref_key;
         miss_pulse <= !abort && byte_vld && got_next == 8'hFF && key_next != ref_key;
      end
   end

endmodule

//--- design/fsk_flash_security.sv
// Flash security and protection option block with an Avalon-MM register slave.
// Assumes the flash array presents its nonvolatile bytes as steady inputs and
// the CPU marks each access with its origin (secure code, debug port).
// Limitation: a mismatch only pulses inside; there is no lockout after repeated guesses.
// Key bytes stay readable at their indices; hiding them is left to the bus fabric.
//
// Notes on behaviour
// - Each reset reloads the working protection and option registers from the nonvolatile bytes.
// - The 8-byte key can lift security only while the key-enable bit is one.
// - Key bytes are accepted only from code running in secure memory.
// - The debug port has no way to enter or submit a key.
// - With key-enable programmed to zero no key match ever lifts security.
// - Without the key, security lifts only after a mass erase followed by a passing blank check.
// - Security field value 1:0 means unsecured; every other value means secured.
// - The 8-byte backdoor key lives in the nonvolatile area and is visible there.
`timescale 1ns/1ps
`include "fsk_regs.svh"

module fsk_flash_security import fsk_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Avalon-MM slave
   input wire logic [17:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Origin of the current access
   input wire logic cpu_in_secure,
   input wire logic bdm_access,
   // Nonvolatile contents and flash engine events
   input wire logic [63:0] nv_key_in,
   input wire logic [7:0] nv_prot_in,
   input wire logic [7:0] nv_opt_in,
   input wire logic mass_erase_done,
   input wire logic blank_check_pass,
   // Security and protection outputs
   output logic mem_secure,
   output logic vector_redirect_disable,
   output logic [6:0] protect_boundary_field,
   output logic protect_disable_bit
);

   // ****************************************
   // State
   // ****************************************
   fsk_bus_e bus_reg;
   logic load_pend_reg;
   logic [7:0] flash_option_working_reg;
   logic [7:0] flash_config_key_access_reg;
   logic [7:0] flash_protect_working_reg;
   logic unlocked_reg;
   logic reject_reg;
   logic erased_reg;
   logic [31:0] rdata_next;

   // ****************************************
   // Decode
   // ****************************************
   logic [15:0] idx;
   logic req;
   logic wr_go;
   logic lane0;
   logic key_hit;
   logic key_enable_bit;
   logic key_access_select;
   logic [1:0] sec_field;
   logic key_write;
   logic key_vld;
   logic key_reject;
   logic cmp_match;
   logic cmp_miss;
   logic key_unlock;
   logic erase_unlock;

   assign idx = avs_address[17:2];
   assign req = avs_read || avs_write;
   assign lane0 = avs_byteenable[0];
   // Writes take effect at the edge where waitrequest is seen low
   assign wr_go = avs_write && bus_reg == FSK_BUS_ANSWER && lane0;
   // The eight key bytes share one decode; the low three index bits pick the byte
   assign key_hit = idx >= `FSK_IDX_KEY_LO && idx <= `FSK_IDX_KEY_HI;
   assign key_enable_bit = flash_option_working_reg[`FSK_OPT_KEY_ENABLE_BIT];
   assign key_access_select = flash_config_key_access_reg[`FSK_CFG_KEY_ACCESS_SELECT];
   assign sec_field = flash_option_working_reg[1:0];
   assign key_write = wr_go && key_hit && key_access_select;

   // A refused byte never reaches the comparator, so no partial key can be seeded
   // only secure code may enter key bytes
   // debug accesses never reach the comparator
   // a disabled key refuses every byte
   assign key_vld = key_write && cpu_in_secure && !bdm_access && key_enable_bit;
   assign key_reject = key_write && !key_vld;

   // a match counts only while key-enable reads one
   assign key_unlock = cmp_match && key_enable_bit;
   // erase then blank check opens the part
   assign erase_unlock = erased_reg && blank_check_pass;

   // ****************************************
   // Key comparator
   // ****************************************
   fsk_key_cmp u_cmp (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .byte_vld(key_vld),
      .byte_idx(idx[2:0]),
      .byte_data(avs_writedata[7:0]),
      .abort(!key_access_select),
      .ref_key(nv_key_in),
      .match_pulse(cmp_match),
      .miss_pulse(cmp_miss)
   );

   // ****************************************
   // Bus slave
   // ****************************************
   // Read mux; unmapped indices read zero
   // Status bits sit in the low lane; the upper lanes always read zero
   always_comb begin
      rdata_next = 32'h0;
      if (key_hit) begin
         // stored key visible in the nonvolatile area
         rdata_next[7:0] = fsk_key_byte(nv_key_in, idx[2:0]);
      end else begin
         unique case (idx)
            `FSK_IDX_OPT: rdata_next[7:0] = flash_option_working_reg;
            `FSK_IDX_CFG: rdata_next[7:0] = flash_config_key_access_reg;
            `FSK_IDX_PROT: rdata_next[7:0] = flash_protect_working_reg;
            `FSK_IDX_KSTAT: rdata_next[2:0] = {erased_reg, reject_reg, unlocked_reg};
            `FSK_IDX_NV_PROTECT_BYTE: rdata_next[7:0] = nv_prot_in;
            `FSK_IDX_NV_OPTION_BYTE: rdata_next[7:0] = nv_opt_in;
            default: rdata_next = 32'h0;
         endcase
      end
   end

   // One wait cycle per access; held off while the reload is pending
   // Read data holds until the next answer, so a late sample still sees it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_reg <= FSK_BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end else begin
         unique case (bus_reg)
            FSK_BUS_IDLE: begin
               if (req && !load_pend_reg) begin
                  bus_reg <= FSK_BUS_ANSWER;
                  avs_waitrequest <= 1'b0;
                  avs_readdata <= rdata_next;
               end
            end
            FSK_BUS_ANSWER: begin
               bus_reg <= FSK_BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // ****************************************
   // Working registers
   // ****************************************
   // reload at the first edge after reset release; a reset may not sample inputs
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         load_pend_reg <= 1'b1;
         flash_option_working_reg <= `FSK_RST_OPT;
         flash_protect_working_reg <= `FSK_RST_PROT;
      end else if (load_pend_reg) begin
         load_pend_reg <= 1'b0;
         flash_option_working_reg <= nv_opt_in & `FSK_OPT_MASK;
         flash_protect_working_reg <= nv_prot_in;
      end else if (wr_go && idx == `FSK_IDX_PROT) begin
         flash_protect_working_reg <= avs_writedata[7:0];
      end
   end

   // Key access select is the only writable configuration bit
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         flash_config_key_access_reg <= `FSK_RST_CFG;
      end else if (wr_go && idx == `FSK_IDX_CFG) begin
         flash_config_key_access_reg <= avs_writedata[7:0] & `FSK_CFG_MASK;
      end
   end

   // Refused key bytes; write one to clear, a new refusal wins over the clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reject_reg <= 1'b0;
      end else if (key_reject) begin
         reject_reg <= 1'b1;
      end else if (wr_go && idx == `FSK_IDX_KSTAT && avs_writedata[`FSK_KST_REJ]) begin
         reject_reg <= 1'b0;
      end
   end

   // ****************************************
   // Security state
   // ****************************************
   // remember a finished mass erase until reset
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         erased_reg <= 1'b0;
      end else if (mass_erase_done) begin
         erased_reg <= 1'b1;
      end
   end

   // unlock holds until reset
   // Nothing but reset clears it; a later wrong key cannot relock the part
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         unlocked_reg <= 1'b0;
      end else if (key_unlock || erase_unlock) begin
         unlocked_reg <= 1'b1;
      end
   end

   // only code 1:0 is open; secure until the reload settles
   // No open window can follow a reset while the option byte is still loading
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_secure <= 1'b1;
      end else begin
         mem_secure <= load_pend_reg || (sec_field != `FSK_SEC_OPEN && !unlocked_reg);
      end
   end

   // Protection and redirect controls follow the working registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         vector_redirect_disable <= 1'b0;
         protect_boundary_field <= 7'h7F;
         protect_disable_bit <= 1'b1;
      end else begin
         vector_redirect_disable <= flash_option_working_reg[`FSK_OPT_NORED];
         protect_boundary_field <= flash_protect_working_reg[7:1];
         protect_disable_bit <= flash_protect_working_reg[`FSK_PROT_DIS];
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   // All checks run on core_clk and pause while reset is low
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // Sampled reset keeps the attempt at the releasing edge out of the check
   a_reload_opt: assert property (rst_b && load_pend_reg |=>
      flash_option_working_reg == ($past(nv_opt_in) & `FSK_OPT_MASK)
      && flash_protect_working_reg == $past(nv_prot_in) && !load_pend_reg)
      else $error("working registers not reloaded after reset");

   a_key_needs_enable: assert property (key_vld |-> key_enable_bit)
      else $error("key byte taken with key disabled");

   a_key_secure_code: assert property (key_vld |-> cpu_in_secure)
      else $error("key byte taken from non-secure code");

   a_key_no_debug: assert property (bdm_access && avs_write |-> !key_vld)
      else $error("debug write reached the key comparator");

   a_disabled_no_open: assert property (
      (!unlocked_reg && !key_enable_bit && !erase_unlock) |=> !unlocked_reg)
      else $error("security lifted with key disabled");

   a_erase_blank_open: assert property (
      (erased_reg && blank_check_pass) |=> unlocked_reg ##1 !mem_secure)
      else $error("erase and blank check did not lift security");

   a_sec_decode: assert property (!load_pend_reg |=>
      mem_secure == ($past(sec_field) != `FSK_SEC_OPEN && !$past(unlocked_reg)))
      else $error("security state does not follow the option field");

   a_key_read_back: assert property (
      avs_read && key_hit && bus_reg == FSK_BUS_IDLE && !load_pend_reg
      |=> avs_readdata[7:0] == fsk_key_byte($past(nv_key_in), $past(idx[2:0])))
      else $error("stored key byte not read back");

   a_unlock_sticky: assert property (unlocked_reg |=> unlocked_reg)
      else $error("unlock dropped before reset");

   a_bus_one_wait: assert property (
      req && bus_reg == FSK_BUS_IDLE && !load_pend_reg |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after request");

   a_answer_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer held longer than one cycle");

   a_readdata_holds: assert property (avs_waitrequest |-> $stable(avs_readdata))
      else $error("read data changed outside an answer");

   a_readdata_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read lanes not zero");

   a_lane_gate: assert property (wr_go |-> avs_byteenable[0])
      else $error("write taken without lane 0");

   a_no_answer_in_load: assert property (load_pend_reg |-> avs_waitrequest)
      else $error("bus answered before the reload");

   a_secure_until_load: assert property (load_pend_reg |=> mem_secure)
      else $error("memory open before the reload settled");

   a_outputs_follow: assert property (1'b1 |=>
      protect_boundary_field == $past(flash_protect_working_reg[7:1])
      && vector_redirect_disable == $past(flash_option_working_reg[`FSK_OPT_NORED]))
      else $error("protection outputs do not follow the working registers");

   a_cfg_only_key_access_select: assert property ((flash_config_key_access_reg & ~`FSK_CFG_MASK) == 8'h00)
      else $error("reserved configuration bit set");

   a_reject_on_refusal: assert property (key_reject |=> reject_reg)
      else $error("refused key byte not flagged");

   a_match_after_byte: assert property (cmp_match |-> $past(key_vld))
      else $error("key match without an accepted byte");

   a_abort_no_match: assert property (!key_access_select |=> !cmp_match && !cmp_miss)
      else $error("compare result with key access off");

   a_key_opens: assert property (key_unlock |=> unlocked_reg ##1 !mem_secure)
      else $error("matching key did not lift security");

   a_miss_no_open: assert property (
      cmp_miss && !unlocked_reg && !erase_unlock |=> !unlocked_reg)
      else $error("wrong key lifted security");

   a_erase_sticky: assert property (erased_reg |=> erased_reg)
      else $error("mass erase record dropped before reset");

   c_key_open: cover property (key_unlock ##2 !mem_secure);
   c_erase_open: cover property (erase_unlock);
   c_key_refused: cover property (key_reject);
   c_key_mismatch: cover property (cmp_miss);
   c_prot_write: cover property (wr_go && idx == `FSK_IDX_PROT);

endmodule

//--- testbench/fsk_flash_security_test.sv
// Self-checking bench for the flash security block: register reads and writes,
// key entry, erase unlock and the security encodings after reset.
// Assumes fsk_pkg, fsk_regs.svh and the design modules are compiled first.
`timescale 1ns/1ps
`include "fsk_regs.svh"

module fsk_flash_security_test import fsk_pkg::*; ;
   // ****************************************
   // Stimulus signals
   // ****************************************
   localparam logic [63:0] KEY = 64'hA1B2C3D4E5F60718;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [17:0] avs_address = 18'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic cpu_in_secure = 1'b0;
   logic bdm_access = 1'b0;
   logic [7:0] nv_prot_in = 8'hFF;
   logic [7:0] nv_opt_in = 8'h00;
   logic mass_erase_done = 1'b0;
   logic blank_check_pass = 1'b0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic mem_secure;
   logic vector_redirect_disable;
   logic [6:0] protect_boundary_field;
   logic protect_disable_bit;
   logic [31:0] rd_val;
   int err_total = 0;
   int n_checks = 0;

   // Clock, 100 ns period
   always #50 core_clk = ~core_clk;

   fsk_flash_security dut_u (
      .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cpu_in_secure(cpu_in_secure), .bdm_access(bdm_access), .nv_key_in(KEY),
      .nv_prot_in(nv_prot_in), .nv_opt_in(nv_opt_in), .mass_erase_done(mass_erase_done),
      .blank_check_pass(blank_check_pass), .mem_secure(mem_secure),
      .vector_redirect_disable(vector_redirect_disable),
      .protect_boundary_field(protect_boundary_field), .protect_disable_bit(protect_disable_bit)
   );

   // ****************************************
   // Report and compare tasks
   // ****************************************
   task automatic stop_test();
      if (err_total == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   // ****************************************
   // Bus tasks
   // ****************************************
   // One Avalon transfer; an edge passes first so no signal is driven twice in a step
   task automatic bus_xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wdata);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, wdata};
      avs_read <= ~wr;
      avs_write <= wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd_val = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         err_total++;
         $display("[FAIL] %0t bus answer timeout", $time);
         stop_test();
      end
   endtask

   task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input string what);
      bus_xfer(1'b0, idx, 8'h00);
      chk(rd_val, {24'h0, exp}, what);
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      bus_xfer(1'b1, idx, d);
   endtask

   // Reset held for 10 cycles with the given nonvolatile bytes
   task automatic do_reset(input logic [7:0] opt, input logic [7:0] prot);
      rst_b <= 1'b0;
      nv_opt_in <= opt;
      nv_prot_in <= prot;
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
   endtask

   // Eight key bytes with the given origin, then time for the unlock to land
   task automatic enter_key(input logic sec, input logic bdm, input logic [63:0] k);
      cpu_in_secure <= sec;
      bdm_access <= bdm;
      for (int i = 0; i < 8; i++) begin
         wr(16'(`FSK_IDX_KEY_LO + i), k[63 - 8 * i -: 8]);
      end
      repeat (3) @(posedge core_clk);
   endtask

   task automatic pulse(input logic erase);
      @(posedge core_clk);
      mass_erase_done <= erase;
      blank_check_pass <= ~erase;
      @(posedge core_clk);
      mass_erase_done <= 1'b0;
      blank_check_pass <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      do_reset(8'h83, 8'hA5);
      rd(`FSK_IDX_OPT, 8'h83, "option copy");
      rd(`FSK_IDX_PROT, 8'hA5, "protect copy");
      chk({25'h0, protect_boundary_field}, 32'h52, "boundary");
      chk_flag(protect_disable_bit, 1'b1, "protect disable");
      chk_flag(vector_redirect_disable, 1'b0, "redirect");
      chk_flag(mem_secure, 1'b1, "secured 11");
      for (int i = 0; i < 8; i++) begin
         rd(16'(`FSK_IDX_KEY_LO + i), KEY[63 - 8 * i -: 8], "key byte");
      end
      rd(`FSK_IDX_NV_PROTECT_BYTE, 8'hA5, "nv protect");
      rd(`FSK_IDX_NV_OPTION_BYTE, 8'h83, "nv option");
      rd(16'h1000, 8'h00, "unmapped");
      wr(`FSK_IDX_OPT, 8'h00);
      rd(`FSK_IDX_OPT, 8'h83, "option read only");
      wr(`FSK_IDX_PROT, 8'h3C);
      rd(`FSK_IDX_PROT, 8'h3C, "protect rw");
      chk({25'h0, protect_boundary_field}, 32'h1E, "boundary write");
      chk_flag(protect_disable_bit, 1'b0, "disable write");
      // A write with lane 0 off must leave the register alone
      avs_byteenable <= 4'hE;
      wr(`FSK_IDX_PROT, 8'h00);
      rd(`FSK_IDX_PROT, 8'h3C, "lane 0 off");
      avs_byteenable <= 4'hF;
      wr(`FSK_IDX_CFG, 8'hFF);
      rd(`FSK_IDX_CFG, 8'h20, "config mask");
      // Debug port, then non-secure code, then a wrong key: all must fail
      enter_key(1'b1, 1'b1, KEY);
      chk_flag(mem_secure, 1'b1, "debug key");
      rd(`FSK_IDX_KSTAT, 8'h02, "debug refused");
      wr(`FSK_IDX_KSTAT, 8'h02);
      enter_key(1'b0, 1'b0, KEY);
      chk_flag(mem_secure, 1'b1, "nonsecure key");
      rd(`FSK_IDX_KSTAT, 8'h02, "nonsecure refused");
      wr(`FSK_IDX_KSTAT, 8'h02);
      enter_key(1'b1, 1'b0, ~KEY);
      chk_flag(mem_secure, 1'b1, "wrong key");
      // Dropping key access halfway abandons the bytes already taken
      for (int i = 0; i < 8; i++) begin
         if (i == 4) begin
            wr(`FSK_IDX_CFG, 8'h00);
            wr(`FSK_IDX_CFG, 8'h20);
         end
         wr(16'(`FSK_IDX_KEY_LO + i), KEY[63 - 8 * i -: 8]);
      end
      repeat (3) @(posedge core_clk);
      chk_flag(mem_secure, 1'b1, "abandoned key");
      enter_key(1'b1, 1'b0, KEY);
      chk_flag(mem_secure, 1'b0, "good key");
      rd(`FSK_IDX_KSTAT, 8'h01, "unlocked");
      // Unlock lasts only until the next reset
      do_reset(8'h83, 8'hA5);
      rd(`FSK_IDX_OPT, 8'h83, "reload");
      chk_flag(mem_secure, 1'b1, "relock");
      // Key disabled: the right key does nothing, erase plus blank check does
      do_reset(8'h03, 8'hFF);
      wr(`FSK_IDX_CFG, 8'h20);
      enter_key(1'b1, 1'b0, KEY);
      chk_flag(mem_secure, 1'b1, "key disabled");
      pulse(1'b0);
      chk_flag(mem_secure, 1'b1, "blank without erase");
      pulse(1'b1);
      chk_flag(mem_secure, 1'b1, "erase alone");
      rd(`FSK_IDX_KSTAT, 8'h06, "erase seen");
      pulse(1'b0);
      chk_flag(mem_secure, 1'b0, "erase and blank");
      // Every security encoding; only 1:0 is open
      for (int e = 0; e < 4; e++) begin
         do_reset({6'h00, 2'(e)}, 8'hFF);
         rd(`FSK_IDX_OPT, {6'h00, 2'(e)}, "encoding");
         chk_flag(mem_secure, (e != 2), "security state");
      end
      stop_test();
   end
endmodule
